// file: hw/twc_pkg.sv
// package of constants and carrier types for the 8-bit waveform/compare timer
// ----------------------------------------------------------------------------
// Notes on behaviour
// R1: clear-on-match mode 2 uses compare_value_a as top and clears count on equality.
// R2: in clear-on-match, compare writes act at once; a low value misses until wrap.
// R3: clear-on-match toggle action inverts output a on each match.
// R4: clear-on-match sets overflow when the count passes from maximum to zero.
// R5: fast pwm sets overflow each time the count reaches top.
// R6: fast pwm top is 0xFF in mode 3, compare_value_a in mode 7.
// R7: pwm action two is non-inverted, action three is inverted.
// R8: fast pwm drives output on match and the opposite level at top-to-zero.
// R9: fast pwm compare zero gives a spike; maximum gives a constant level.
// R10: fast pwm toggle action toggles on match with buffered compare values.
// R11: phase-correct modes 1 and 5 count up to top then down to zero.
// R12: phase-correct count holds top for exactly one timer cycle.
// R13: phase-correct sets overflow each time the count reaches zero.
// R14: phase-correct non-inverted clears on up match, sets on down match.
// R15: phase-correct compare zero holds low, maximum holds high, inverted opposite.
// R16: phase-correct output changes at zero without a match to keep symmetry.
// R17: both compares checked always; flag set on the following timer cycle.
// R18: compare flag clears on interrupt service or software write of one.
// R19: pwm modes buffer compare writes until top or bottom; others write directly. The code loads the buffer at top in both fast and phase-correct modes.
// R20: force strobe applies the action in non-pwm modes, no flag, no clear.
// R21: a count write blocks every compare match in the next timer cycle.
// R22: output register survives mode changes; action changes act immediately.
// R23: bottom is 0x00, maximum 0xFF, top is maximum or compare_value_a.
// R24: normal mode 0 counts up, wraps, sets overflow as count becomes zero.
// R25: action zero leaves the output register unchanged on a match.
// R26: updates happen only on timer enable edges, software writes at once.
// ----------------------------------------------------------------------------
package twc_pkg;
  localparam int TWC_W = 8;
  localparam logic [7:0] TWC_BOTTOM = 8'h00;
  localparam logic [7:0] TWC_MAX = 8'hFF;
  localparam logic [2:0] TWC_M_NORMAL = 3'h0;
  localparam logic [2:0] TWC_M_PC_FF = 3'h1;
  localparam logic [2:0] TWC_M_CLR = 3'h2;
  localparam logic [2:0] TWC_M_FAST_FF = 3'h3;
  localparam logic [2:0] TWC_M_PC_A = 3'h5;
  localparam logic [2:0] TWC_M_FAST_A = 3'h7;
  localparam logic [1:0] TWC_ACT_NONE = 2'h0;
  localparam logic [1:0] TWC_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TWC_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TWC_ACT_SET = 2'h3;
  localparam logic [7:0] TWC_RST_COUNT = 8'h00;
  localparam logic [7:0] TWC_RST_CMP = 8'h00;
  localparam logic TWC_RST_OUT = 1'b0;

  // software write port of one 8-bit value
  typedef struct packed {
    logic we;
    logic [7:0] data;
  } twc_wr_t;

  // counter events shared with the compare channels
  typedef struct packed {
    logic tick;
    logic up;
    logic at_top;
    logic at_bottom;
    logic wrap_fast;
    logic blocked;
    logic pwm;
    logic fast;
    logic phase;
  } twc_cnt_t;
endpackage

// file: hw/twc_counter.sv
// up/down counter with top selection and overflow detection
`timescale 1ns/10ps
module twc_counter (
  input wire logic mclk_in,                  // system clock
  input wire logic rst_n_in,                 // sync reset, active low
  input wire logic tick_in,                  // timer clock enable
  input wire logic [2:0] mode_in,            // waveform_mode_sel
  input wire logic [7:0] top_a_in,           // live compare_value_a
  input wire twc_pkg::twc_wr_t count_wr_in,  // software count write
  output logic [7:0] count_out,              // timer_count
  output logic up_out,                       // counting direction
  output logic ovf_ev_out,                   // overflow event, one cycle
  output logic blocked_out                   // compare block after write
);
  import twc_pkg::*;

  logic [7:0] count_r, count_nxt;
  logic up_r, up_nxt;
  logic blocked_r;
  wire phase_w = (mode_in == TWC_M_PC_FF) || (mode_in == TWC_M_PC_A);
  wire use_a_w = (mode_in == TWC_M_CLR) || (mode_in == TWC_M_PC_A) || (mode_in == TWC_M_FAST_A);
  wire [7:0] top_w = use_a_w ? top_a_in : TWC_MAX; // [R23]
  wire at_top_w = (count_r == top_w);
  wire clr_w = (mode_in == TWC_M_CLR);

  // next count: clear-on-match clears on top, fast wraps at top, phase reverses at ends
  always_comb begin
    count_nxt = count_r;
    up_nxt = up_r;
    if (phase_w) begin
      if (up_r && at_top_w) begin
        up_nxt = 1'b0; // top held one cycle, next step goes down [R12]
        count_nxt = count_r - 8'h01;
      end else if (!up_r && count_r == TWC_BOTTOM) begin
        up_nxt = 1'b1;
        count_nxt = count_r + 8'h01;
      end else begin
        count_nxt = up_r ? count_r + 8'h01 : count_r - 8'h01; // [R11]
      end
    end else begin
      up_nxt = 1'b1;
      // a value written below the count rolls through 0xFF [R2]
      if ((clr_w || mode_in == TWC_M_FAST_FF || mode_in == TWC_M_FAST_A) && at_top_w) begin
        count_nxt = TWC_BOTTOM; // [R1] [R6]
      end else begin
        count_nxt = count_r + 8'h01; // [R24]
      end
    end
  end

  // overflow cause per mode, sampled on the enable edge
  wire ovf_w = phase_w ? (count_nxt == TWC_BOTTOM) && (count_r != TWC_BOTTOM) // [R13]
             : (mode_in == TWC_M_FAST_FF || mode_in == TWC_M_FAST_A) ? at_top_w // [R5]
             : (count_r == TWC_MAX); // [R4] [R24]

  // software write overrides counting and arms the block [R21] [R26]
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      count_r <= TWC_RST_COUNT;
      up_r <= 1'b1;
      blocked_r <= 1'b0;
    end else begin
      if (count_wr_in.we) begin
        count_r <= count_wr_in.data;
        blocked_r <= 1'b1; // [R21]
      end else if (tick_in) begin
        count_r <= count_nxt;
        up_r <= up_nxt;
        blocked_r <= 1'b0;
      end
    end
  end

  assign count_out = count_r;
  assign up_out = up_r;
  // left unregistered: the flag flop in the top is the only delay stage
  assign ovf_ev_out = tick_in && !count_wr_in.we && ovf_w;
  assign blocked_out = blocked_r;
endmodule

// file: hw/twc_channel.sv
// one compare channel: buffer, comparator, flag event and output register
`timescale 1ns/10ps
module twc_channel (
  input wire logic mclk_in,                // system clock
  input wire logic rst_n_in,               // sync reset, active low
  input wire twc_pkg::twc_cnt_t cnt_in,    // counter events
  input wire logic [7:0] count_in,         // timer_count
  input wire logic [1:0] action_in,        // compare_output_action
  input wire twc_pkg::twc_wr_t cmp_wr_in,  // software compare write
  input wire logic force_in,               // force_compare_strobe
  output logic [7:0] cmp_out,              // active compare value
  output logic match_ev_out,               // match event on a tick edge
  output logic oc_out                      // compare output register
);
  import twc_pkg::*;

  logic [7:0] cmp_r, buf_r;
  logic oc_r, oc_nxt, up_hit_r;
  wire match_w = (count_in == cmp_r) && !cnt_in.blocked; // [R17] [R21]
  wire inv_w = (action_in == TWC_ACT_SET);
  wire pwm_act_w = action_in[1]; // [R7]
  // an up-slope match seen since the last bottom; the constant maximum does not count
  wire up_hit_nxt = cnt_in.at_bottom ? 1'b0 : (up_hit_r || (match_w && cnt_in.up && cmp_r != TWC_MAX));

  // output next value per mode; action zero never touches it [R25] [R22]
  always_comb begin
    oc_nxt = oc_r;
    if (cnt_in.pwm) begin
      if (action_in == TWC_ACT_TOGGLE && cnt_in.fast && match_w) begin
        oc_nxt = !oc_r; // [R10]
      end else if (pwm_act_w && cnt_in.fast) begin
        if (match_w && cmp_r != TWC_MAX) begin
          oc_nxt = inv_w; // [R8] [R9]
        end else if (cnt_in.wrap_fast) begin
          oc_nxt = (cmp_r == TWC_MAX) ? inv_w : !inv_w; // [R8] [R9]
        end
      end else if (pwm_act_w && cnt_in.phase) begin
        if (cmp_r == TWC_BOTTOM) begin
          oc_nxt = inv_w; // [R15]
        end else if (cmp_r == TWC_MAX) begin
          oc_nxt = !inv_w; // [R15]
        end else if (match_w) begin
          oc_nxt = cnt_in.up ? inv_w : !inv_w; // [R14]
        end else if (cnt_in.at_bottom && !up_hit_r) begin
          oc_nxt = inv_w; // missed up match: take its level at zero [R16]
        end
      end
    end else if (match_w || force_in) begin
      unique case (action_in)
        TWC_ACT_TOGGLE: oc_nxt = !oc_r; // [R3] [R20]
        TWC_ACT_CLEAR: oc_nxt = 1'b0;
        TWC_ACT_SET: oc_nxt = 1'b1;
        TWC_ACT_NONE: oc_nxt = oc_r; // [R25]
      endcase
    end
  end

  // buffer load at top (fast and phase); direct otherwise [R19]
  wire load_w = cnt_in.tick && ((cnt_in.fast && cnt_in.at_top) || (cnt_in.phase && cnt_in.at_top));
  wire direct_w = cmp_wr_in.we && !cnt_in.pwm;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cmp_r <= TWC_RST_CMP;
      buf_r <= TWC_RST_CMP;
      oc_r <= TWC_RST_OUT;
      up_hit_r <= 1'b0;
    end else begin
      if (cmp_wr_in.we) begin
        buf_r <= cmp_wr_in.data;
      end
      if (direct_w) begin
        cmp_r <= cmp_wr_in.data; // [R2] [R19]
      end else if (load_w) begin
        cmp_r <= buf_r; // [R19]
      end
      if (cnt_in.tick) begin
        up_hit_r <= up_hit_nxt; // [R16]
      end
      if (cnt_in.tick || (force_in && !cnt_in.pwm)) begin
        oc_r <= (force_in && !cnt_in.tick) ? (action_in == TWC_ACT_TOGGLE ? !oc_r
                : action_in == TWC_ACT_CLEAR ? 1'b0 : action_in == TWC_ACT_SET ? 1'b1 : oc_r)
                : oc_nxt; // force acts on the write cycle, no flag [R20]
      end
    end
  end

  assign cmp_out = cmp_r;
  // unregistered so the flag rises right after the matching tick edge
  assign match_ev_out = cnt_in.tick && match_w; // [R17] [R26]
  assign oc_out = oc_r;
endmodule

// file: hw/twc_top.sv
// 8-bit timer waveform generation and output compare top level
`timescale 1ns/10ps
module twc_top (
  input wire logic mclk_in,                  // 200 MHz system clock
  input wire logic rst_n_in,                 // sync reset, active low
  input wire logic tick_in,                  // prescaled timer enable pulse
  input wire logic [2:0] mode_in,            // waveform_mode_sel
  input wire logic [1:0] action_a_in,        // compare_output_action a
  input wire logic [1:0] action_b_in,        // compare_output_action b
  input wire twc_pkg::twc_wr_t count_wr_in,  // timer_count write
  input wire twc_pkg::twc_wr_t cmp_a_wr_in,  // compare_value_a write
  input wire twc_pkg::twc_wr_t cmp_b_wr_in,  // compare_value_b write
  input wire logic force_a_in,               // force_compare_strobe a
  input wire logic force_b_in,               // force_compare_strobe b
  input wire logic [2:0] flag_clr_in,        // write-one clear {ovf,b,a}
  input wire logic [2:0] svc_ack_in,         // interrupt serviced {ovf,b,a}
  output logic [7:0] count_out,              // timer_count
  output logic [7:0] cmp_a_out,              // active compare_value_a
  output logic [7:0] cmp_b_out,              // active compare_value_b
  output logic compare_flag_a_out,           // compare_flag_a
  output logic compare_flag_b_out,           // compare_flag_b
  output logic overflow_flag_out,            // overflow_flag
  output logic compare_output_a_out,         // compare_output_a
  output logic compare_output_b_out          // compare_output_b
);
  import twc_pkg::*;

  // ------------------------------------------------------------------
  // counter
  // ------------------------------------------------------------------
  logic [7:0] count_w, cmp_a_w, cmp_b_w;
  logic up_w, ovf_ev_w, blocked_w, mat_a_w, mat_b_w, oc_a_w, oc_b_w;
  twc_cnt_t cnt_w;

  twc_counter u_cnt (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .tick_in(tick_in),
    .mode_in(mode_in),
    .top_a_in(cmp_a_w),
    .count_wr_in(count_wr_in),
    .count_out(count_w),
    .up_out(up_w),
    .ovf_ev_out(ovf_ev_w),
    .blocked_out(blocked_w)
  );

  // shared decode of counter state for both channels
  wire fast_w = (mode_in == TWC_M_FAST_FF) || (mode_in == TWC_M_FAST_A);
  wire phase_w = (mode_in == TWC_M_PC_FF) || (mode_in == TWC_M_PC_A);
  wire [7:0] top_w = (mode_in == TWC_M_FAST_A || mode_in == TWC_M_PC_A) ? cmp_a_w : TWC_MAX;
  assign cnt_w.tick = tick_in && !count_wr_in.we;
  assign cnt_w.up = up_w;
  assign cnt_w.at_top = (count_w == top_w);
  assign cnt_w.at_bottom = (count_w == TWC_BOTTOM) && !up_w;
  assign cnt_w.wrap_fast = fast_w && (count_w == top_w); // [R8]
  assign cnt_w.blocked = blocked_w; // [R21]
  assign cnt_w.pwm = fast_w || phase_w;
  assign cnt_w.fast = fast_w;
  assign cnt_w.phase = phase_w;

  // ------------------------------------------------------------------
  // compare channels
  // ------------------------------------------------------------------
  twc_channel u_ch_a (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .cnt_in(cnt_w),
    .count_in(count_w),
    .action_in(action_a_in),
    .cmp_wr_in(cmp_a_wr_in),
    .force_in(force_a_in),
    .cmp_out(cmp_a_w),
    .match_ev_out(mat_a_w),
    .oc_out(oc_a_w)
  );

  twc_channel u_ch_b (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .cnt_in(cnt_w),
    .count_in(count_w),
    .action_in(action_b_in),
    .cmp_wr_in(cmp_b_wr_in),
    .force_in(force_b_in),
    .cmp_out(cmp_b_w),
    .match_ev_out(mat_b_w),
    .oc_out(oc_b_w)
  );

  // ------------------------------------------------------------------
  // sticky flags: a set in the clearing cycle wins
  // ------------------------------------------------------------------
  logic [2:0] flags_r;
  wire [2:0] set_w = {ovf_ev_w, mat_b_w, mat_a_w};
  wire [2:0] flags_nxt = set_w | (flags_r & ~(flag_clr_in | svc_ack_in)); // [R18]

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      flags_r <= 3'h0;
    end else begin
      flags_r <= flags_nxt; // [R17] [R4] [R5] [R13]
    end
  end

  assign count_out = count_w;
  assign cmp_a_out = cmp_a_w;
  assign cmp_b_out = cmp_b_w;
  assign compare_flag_a_out = flags_r[0];
  assign compare_flag_b_out = flags_r[1];
  assign overflow_flag_out = flags_r[2];
  assign compare_output_a_out = oc_a_w;
  assign compare_output_b_out = oc_b_w;
endmodule

// file: verification/twc_properties.sv
// concurrent checks on the ports of the waveform/compare timer
`timescale 1ns/10ps
module twc_checker import twc_pkg::*; (
  input wire logic mclk_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic tick_in, // timer enable
  input wire logic [2:0] mode_in, // mode
  input wire logic [1:0] action_a_in, // action a
  input wire logic [1:0] action_b_in, // action b
  input wire twc_pkg::twc_wr_t count_wr_in, // count write
  input wire twc_pkg::twc_wr_t cmp_a_wr_in, // compare a write
  input wire twc_pkg::twc_wr_t cmp_b_wr_in, // compare b write
  input wire logic force_a_in, // force a
  input wire logic force_b_in, // force b
  input wire logic [2:0] flag_clr_in, // flag clear
  input wire logic [2:0] svc_ack_in, // service ack
  input wire logic [7:0] count_out, // count
  input wire logic [7:0] cmp_a_out, // compare a
  input wire logic [7:0] cmp_b_out, // compare b
  input wire logic compare_flag_a_out, // flag a
  input wire logic compare_flag_b_out, // flag b
  input wire logic overflow_flag_out, // overflow
  input wire logic compare_output_a_out, // output a
  input wire logic compare_output_b_out // output b
);
  // ---------------------------------------------------------------
  // one clock domain, so clocking and reset are declared once
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  // a tick the counter really takes: a count write would win over it
  wire logic go = tick_in & ~count_wr_in.we;

  property p_cm_clear;
    mode_in == 3'h2 && go && count_out == cmp_a_out |=> count_out == 8'h00;
  endproperty
  a_cm_clear: assert property (p_cm_clear) else $error("count not cleared on match");
  property p_cm_ovf;
    mode_in == 3'h2 && go && count_out == 8'hFF |=> overflow_flag_out && count_out == 8'h00;
  endproperty
  a_cm_ovf: assert property (p_cm_ovf) else $error("no overflow at wrap");
  property p_fast_top;
    mode_in == 3'h3 && go && count_out == 8'hFF |=> overflow_flag_out && count_out == 8'h00;
  endproperty
  a_fast_top: assert property (p_fast_top) else $error("fast top wrong");
  property p_pc_hold;
    mode_in == 3'h1 && go && count_out == 8'hFF |=> count_out == 8'hFE;
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("top not left downward");
  property p_pc_ovf;
    (mode_in == 3'h1 || mode_in == 3'h5) && go && count_out == 8'h01
      && $past(count_out) == 8'h02 && !$past(count_wr_in.we)
      |=> overflow_flag_out && count_out == 8'h00;
  endproperty
  a_pc_ovf: assert property (p_pc_ovf) else $error("no overflow at bottom");
  property p_flag_a;
    go && count_out == cmp_a_out && $past(tick_in) && !$past(count_wr_in.we)
      |=> compare_flag_a_out;
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("match flag a missing");
  property p_block;
    $rose(compare_flag_b_out) |-> !$past(count_wr_in.we, 2);
  endproperty
  a_block: assert property (p_block) else $error("match after count write");
  property p_force;
    (mode_in == 3'h0 || mode_in == 3'h2) && force_a_in && !tick_in && action_a_in == 2'h1
      |=> compare_output_a_out != $past(compare_output_a_out);
  endproperty
  a_force: assert property (p_force) else $error("force did not toggle");
endmodule
bind twc_top twc_checker i_twc_checker (.mclk_in, .rst_n_in, .tick_in, .mode_in,
  .action_a_in, .action_b_in, .count_wr_in, .cmp_a_wr_in, .cmp_b_wr_in, .force_a_in,
  .force_b_in, .flag_clr_in, .svc_ack_in, .count_out, .cmp_a_out, .cmp_b_out,
  .compare_flag_a_out, .compare_flag_b_out, .overflow_flag_out, .compare_output_a_out,
  .compare_output_b_out);

// file: verification/twc_top_test.sv
// self-checking testbench of the waveform/compare timer
`timescale 1ns/10ps
module twc_top_test;
  import twc_pkg::*;
  logic mclk_in, rst_n_in, tick_in, force_a_in, force_b_in;
  logic [2:0] mode_in, flag_clr_in, svc_ack_in;
  logic [1:0] action_a_in, action_b_in;
  twc_wr_t count_wr_in, cmp_a_wr_in, cmp_b_wr_in;
  logic [7:0] count_out, cmp_a_out, cmp_b_out;
  logic compare_flag_a_out, compare_flag_b_out, overflow_flag_out;
  logic compare_output_a_out, compare_output_b_out;
  int error_cnt = 0;
  int n_tests = 0;

  twc_top i_twc_top (.mclk_in, .rst_n_in, .tick_in, .mode_in, .action_a_in, .action_b_in,
    .count_wr_in, .cmp_a_wr_in, .cmp_b_wr_in, .force_a_in, .force_b_in, .flag_clr_in,
    .svc_ack_in, .count_out, .cmp_a_out, .cmp_b_out, .compare_flag_a_out,
    .compare_flag_b_out, .overflow_flag_out, .compare_output_a_out, .compare_output_b_out);

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic st();
    @(posedge mclk_in);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for a count value; a miss counts as a mismatch
  task automatic wt(input logic [7:0] v);
    int i;
    i = 0;
    while (count_out !== v && i < 600) begin
      st();
      i++;
    end
    if (i == 600) chk(count_out, v);
  endtask
  // one-cycle write pulse: 0 count, 1 compare a, 2 compare b
  task automatic wr(input logic [1:0] k, input logic [7:0] v);
    @(posedge mclk_in);
    if (k == 2'h0) count_wr_in <= '{1'b1, v};
    else if (k == 2'h1) cmp_a_wr_in <= '{1'b1, v};
    else cmp_b_wr_in <= '{1'b1, v};
    @(posedge mclk_in);
    count_wr_in.we <= 1'b0;
    cmp_a_wr_in.we <= 1'b0;
    cmp_b_wr_in.we <= 1'b0;
    #1;
  endtask
  // one-cycle strobe: 0 force a, 1 flag clear, 2 service ack, 3 force b
  task automatic pl(input logic [1:0] k, input logic [2:0] v);
    @(posedge mclk_in);
    if (k == 2'h0) force_a_in <= v[0];
    else if (k == 2'h1) flag_clr_in <= v;
    else if (k == 2'h2) svc_ack_in <= v;
    else force_b_in <= v[0];
    @(posedge mclk_in);
    force_a_in <= 1'b0;
    force_b_in <= 1'b0;
    flag_clr_in <= 3'h0;
    svc_ack_in <= 3'h0;
    #1;
  endtask
  task automatic summarize();
    $display("tests=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // timer stopped so only the strobe can move the output
  task automatic t_force();
    for (int i = 3; i > 0; i--) begin
      action_a_in <= 2'(i);
      pl(2'h0, 3'h1);
      chk(8'(compare_output_a_out), 8'(i != 2));
    end
    chk(8'(compare_flag_a_out), 8'h00);
    action_b_in <= 2'h3;
    pl(2'h3, 3'h1);
    chk(8'(compare_output_b_out), 8'h01);
  endtask
  task automatic t_block();
    wr(2'h2, 8'h30);
    chk(cmp_b_out, 8'h30);
    wr(2'h0, 8'h30);
    @(posedge mclk_in);
    tick_in <= 1'b1;
    @(posedge mclk_in);
    tick_in <= 1'b0;
    #1;
    chk(count_out, 8'h31);
    chk(8'(compare_flag_b_out), 8'h00);
    wr(2'h0, 8'h2F);
    tick_in <= 1'b1;
    wt(8'h31);
    chk(8'(compare_flag_b_out), 8'h01);
  endtask
  task automatic t_clr();
    logic o;
    mode_in <= 3'h2;
    action_a_in <= 2'h1;
    wr(2'h1, 8'h03);
    wr(2'h0, 8'h00);
    wt(8'h03);
    o = compare_output_a_out;
    st();
    chk(count_out, 8'h00);
    chk(8'(compare_output_a_out), 8'(!o));
    chk(8'(compare_flag_a_out), 8'h01);
    pl(2'h2, 3'h1);
    chk(8'(compare_flag_a_out), 8'h00);
    wr(2'h0, 8'h05);
    pl(2'h1, 3'h4);
    chk(8'(overflow_flag_out), 8'h00);
    wt(8'hFF);
    st();
    chk(count_out, 8'h00);
    chk(8'(overflow_flag_out), 8'h01);
  endtask
  task automatic t_fast();
    mode_in <= 3'h0;
    wr(2'h1, 8'h10);
    wr(2'h0, 8'h20);
    mode_in <= 3'h3;
    action_a_in <= 2'h2;
    pl(2'h1, 3'h4);
    wt(8'hFF);
    st();
    chk(count_out, 8'h00);
    chk(8'(overflow_flag_out), 8'h01);
    chk(8'(compare_output_a_out), 8'h01);
    wr(2'h1, 8'h40);
    chk(cmp_a_out, 8'h10);
    wt(8'h12);
    chk(8'(compare_output_a_out), 8'h00);
    wt(8'hFF);
    st();
    chk(cmp_a_out, 8'h40);
  endtask
  task automatic t_phase();
    mode_in <= 3'h0;
    wr(2'h2, 8'h80);
    wr(2'h0, 8'h00);
    mode_in <= 3'h1;
    action_b_in <= 2'h2;
    wt(8'hFF);
    chk(8'(compare_output_b_out), 8'h00);
    st();
    chk(count_out, 8'hFE);
    wt(8'h7E);
    chk(8'(compare_output_b_out), 8'h01);
    pl(2'h1, 3'h4);
    wt(8'h00);
    chk(8'(overflow_flag_out), 8'h01);
  endtask
  // top taken from compare a in fast mode 7 and phase-correct mode 5
  task automatic t_top();
    mode_in <= 3'h0;
    wr(2'h1, 8'h20);
    wr(2'h0, 8'h00);
    mode_in <= 3'h7;
    wt(8'h20);
    st();
    chk(count_out, 8'h00);
    mode_in <= 3'h5;
    wt(8'h20);
    st();
    chk(count_out, 8'h1F);
  endtask
  // compare value zero, action changes and half-rate toggling
  task automatic t_edge();
    logic o;
    mode_in <= 3'h0;
    wr(2'h1, 8'h00);
    mode_in <= 3'h1;
    action_a_in <= 2'h2;
    st();
    st();
    chk(8'(compare_output_a_out), 8'h00);
    action_a_in <= 2'h3;
    st();
    st();
    chk(8'(compare_output_a_out), 8'h01);
    mode_in <= 3'h2;
    action_a_in <= 2'h0;
    wr(2'h0, 8'h00);
    st();
    st();
    chk(8'(compare_output_a_out), 8'h01);
    action_a_in <= 2'h1;
    st();
    o = compare_output_a_out;
    st();
    chk(8'(compare_output_a_out), 8'(!o));
  endtask

  // ---------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  initial begin
    rst_n_in = 1'b0;
    tick_in = 1'b0;
    mode_in = 3'h0;
    action_a_in = 2'h0;
    action_b_in = 2'h0;
    count_wr_in = '0;
    cmp_a_wr_in = '0;
    cmp_b_wr_in = '0;
    force_a_in = 1'b0;
    force_b_in = 1'b0;
    flag_clr_in = 3'h0;
    svc_ack_in = 3'h0;
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    st();
    t_force();
    t_block();
    t_clr();
    t_fast();
    t_phase();
    t_top();
    t_edge();
    summarize();
  end
  // the sequence needs some 1400 cycles, so this leaves ample margin
  initial begin
    repeat (20000) @(posedge mclk_in);
    error_cnt++;
    summarize();
  end
endmodule
